// ===== rtl/dic_pkg.sv
// Constants and types shared by the digital input conditioner
package dic_pkg;

    // ------------------------------------------------------------
    // Sizes and timing
    // ------------------------------------------------------------
    localparam int NUM_CH         = 2;        // Conditioned inputs
    localparam int CLK_PERIOD_NS  = 100;      // Core clock period
    localparam int MS_PERIOD_NS   = 1000000;  // One delay step
    localparam int SCAN_PERIOD_MS = 5;        // Scan period in ms
    localparam int MS_CYCLES_DFLT = MS_PERIOD_NS / CLK_PERIOD_NS;
    localparam int SCAN_CYCLES_DFLT = SCAN_PERIOD_MS * MS_CYCLES_DFLT;
    localparam int CNT_W          = 16;       // Tick counter width
    localparam int DLY_W          = 21;       // Delay setting, ms
    localparam int QUAL_W         = 22;       // Delay plus AC margin
    localparam logic [DLY_W-1:0]  DLY_MAX_MS  = 21'h1b7740; // 1800 s
    localparam logic [QUAL_W-1:0] AC_EXTRA_MS = 22'h00001e; // 30 ms

    // ------------------------------------------------------------
    // Reset values of per-channel state and of the top-level tick counters
    // ------------------------------------------------------------
    localparam logic              STATE_RST = 1'h0;
    localparam logic [QUAL_W-1:0] QUAL_RST  = 22'h000000;
    localparam logic [CNT_W-1:0]  CNT_RST   = 16'h0000;

    // Per-channel configuration (NO = polarityNc low)
    typedef struct packed {
        logic             polarityNc;   // Invert energized level
        logic             acMode;       // Alternating supply release
        logic [DLY_W-1:0] actDelay;     // Activation delay, ms
        logic [DLY_W-1:0] dropDelay;    // Drop-off delay, ms
    } dic_cfg_t;

    // Per-channel state
    typedef struct packed {
        logic              sampled;     // Scan sample after polarity
        logic              reported;    // Qualified input state
        logic              consumer;    // Seen by internal consumers
        logic              routed;      // Routed output stage
        logic [QUAL_W-1:0] qualCnt;     // Elapsed ms of pending change
    } dic_chan_st_t;

    // Top-level state
    typedef struct packed {
        logic [NUM_CH-1:0] syncA;       // First synchroniser stage
        logic [NUM_CH-1:0] syncB;       // Second synchroniser stage
        logic [CNT_W-1:0]  scanCnt;     // Scan period counter
        logic [CNT_W-1:0]  msCnt;       // Millisecond counter
        logic              scanTick;    // One-cycle scan strobe
        logic              msTick;      // One-cycle ms strobe
    } dic_top_st_t;

endpackage : dic_pkg

// ===== rtl/dic_channel.sv
// One input channel: polarity, qualification delays and stage latency
`timescale 1ns/1ps
module dic_channel (
    input  wire logic             core_clk,       // Core clock
    input  wire logic             sys_rst,        // Sync reset
    input  wire logic             rawIn,          // Synchronised input
    input  wire logic             scanTick,       // Scan strobe
    input  wire logic             msTick,         // Millisecond strobe
    input  wire dic_pkg::dic_cfg_t cfg,           // Channel settings
    output logic                  reportedState,  // Qualified state
    output logic                  consumerState,  // Consumer stage
    output logic                  routedState     // Output stage
);

    dic_pkg::dic_chan_st_t st_r;
    dic_pkg::dic_chan_st_t st_nxt;
    logic [dic_pkg::QUAL_W-1:0] target;
    logic                       qualified;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        // Delay that applies to the pending direction
        if (st_r.sampled) begin
            target = {1'b0, cfg.actDelay};
        end else if (cfg.acMode) begin
            target = {1'b0, cfg.dropDelay} + dic_pkg::AC_EXTRA_MS;
        end else begin
            target = {1'b0, cfg.dropDelay};
        end
        qualified = (st_r.sampled != st_r.reported)
                    && (st_r.qualCnt >= target);
        // Sample and pipeline stages on the scan strobe
        if (scanTick) begin
            st_nxt.sampled  = rawIn ^ cfg.polarityNc;
            st_nxt.consumer = st_r.reported;
            st_nxt.routed   = st_r.consumer;
        end
        // Qualification timer
        if (st_r.sampled == st_r.reported) begin
            st_nxt.qualCnt = dic_pkg::QUAL_RST;
        end else if (qualified) begin
            st_nxt.reported = st_r.sampled;
            st_nxt.qualCnt  = dic_pkg::QUAL_RST;
        end else if (msTick) begin
            st_nxt.qualCnt = st_r.qualCnt + 22'h000001;
        end
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_r <= '{sampled:  dic_pkg::STATE_RST,
                      reported: dic_pkg::STATE_RST,
                      consumer: dic_pkg::STATE_RST,
                      routed:   dic_pkg::STATE_RST,
                      qualCnt:  dic_pkg::QUAL_RST};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reportedState = st_r.reported;
    assign consumerState = st_r.consumer;
    assign routedState   = st_r.routed;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence seq_scan_take;
        scanTick ##1 1'b1;
    endsequence

    chk_polarity_sample: assert property (
        scanTick |=> st_r.sampled == $past(rawIn ^ cfg.polarityNc))
        else $error("sample does not follow polarity");
    chk_change_qualified: assert property (
        !$past(sys_rst) && !$stable(st_r.reported) |-> $past(qualified))
        else $error("reported state changed before its delay");
    chk_zero_delay: assert property (
        (st_r.sampled != st_r.reported) && (target == 22'h000000)
        |=> st_r.reported == $past(st_r.sampled))
        else $error("zero delay did not pass at once");
    chk_ac_release_hold: assert property (
        st_r.reported && !st_r.sampled && cfg.acMode
        && (st_r.qualCnt < dic_pkg::AC_EXTRA_MS) |=> st_r.reported)
        else $error("AC mode released too early");
    chk_consumer_lag: assert property (
        seq_scan_take |-> st_r.consumer == $past(st_r.reported))
        else $error("consumer stage missed scan update");
    chk_routed_lag: assert property (
        seq_scan_take |-> st_r.routed == $past(st_r.consumer))
        else $error("routed stage missed scan update");
    chk_cancel_restart: assert property (
        st_r.sampled == st_r.reported |=> st_r.qualCnt == 22'h000000)
        else $error("pending timer not cancelled");

endmodule : dic_channel

// ===== rtl/dic_top.sv
// Digital input conditioner: scan timebase, synchronisers, channels
//
// Behaviour
// - Polarity per input; normally-open reports energized as 1, the default.
// - Rising reported change waits an activation delay in ms, default zero.
// - Falling reported change waits a separate drop-off delay, default zero.
// - AC mode adds 30 ms to the falling reported change, so zero crossings do not drop a normally-open input.
// - Inputs are sampled once each 5 ms scan period.
// - Internal consumers see the reported state at the following scan.
// - Routed output stage updates one further scan round later.
`timescale 1ns/1ps
module dic_top #(
    parameter int SCAN_CYCLES = dic_pkg::SCAN_CYCLES_DFLT, // 5 ms
    parameter int MS_CYCLES   = dic_pkg::MS_CYCLES_DFLT    // 1 ms
) (
    input  wire logic                        core_clk,      // 10 MHz
    input  wire logic                        sys_rst,       // Sync reset
    input  wire logic [dic_pkg::NUM_CH-1:0]  inputChannel,  // Energized
    input  wire dic_pkg::dic_cfg_t [dic_pkg::NUM_CH-1:0] chanCfg, // Set
    output logic [dic_pkg::NUM_CH-1:0]       inputState,    // Reported
    output logic [dic_pkg::NUM_CH-1:0]       consumerState, // Consumers
    output logic [dic_pkg::NUM_CH-1:0]       outputChannel, // Routed
    output logic                             scanStrobe     // Scan tick
);

    dic_pkg::dic_top_st_t st_r;
    dic_pkg::dic_top_st_t st_nxt;
    logic scanWrap;
    logic msWrap;

    // ------------------------------------------------------------
    // Timebase and synchronisers
    // ------------------------------------------------------------
    always_comb begin
        st_nxt       = st_r;
        scanWrap     = (st_r.scanCnt == dic_pkg::CNT_W'(SCAN_CYCLES - 1));
        msWrap       = (st_r.msCnt == dic_pkg::CNT_W'(MS_CYCLES - 1));
        st_nxt.syncA = inputChannel;
        st_nxt.syncB = st_r.syncA;
        // Scan period counter
        if (scanWrap) begin
            st_nxt.scanCnt = dic_pkg::CNT_RST;
        end else begin
            st_nxt.scanCnt = st_r.scanCnt + 16'h0001;
        end
        // Millisecond counter for delay steps
        if (msWrap) begin
            st_nxt.msCnt = dic_pkg::CNT_RST;
        end else begin
            st_nxt.msCnt = st_r.msCnt + 16'h0001;
        end
        st_nxt.scanTick = scanWrap;
        st_nxt.msTick   = msWrap;
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_r <= '{syncA:    '0,
                      syncB:    '0,
                      scanCnt:  dic_pkg::CNT_RST,
                      msCnt:    dic_pkg::CNT_RST,
                      scanTick: 1'b0,
                      msTick:   1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign scanStrobe = st_r.scanTick;

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    for (genvar i = 0; i < dic_pkg::NUM_CH; i++) begin : g_chan
        dic_channel u_chan (
            .core_clk      (core_clk),
            .sys_rst       (sys_rst),
            .rawIn         (st_r.syncB[i]),
            .scanTick      (st_r.scanTick),
            .msTick        (st_r.msTick),
            .cfg           (chanCfg[i]),
            .reportedState (inputState[i]),
            .consumerState (consumerState[i]),
            .routedState   (outputChannel[i])
        );
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    chk_scan_spacing: assert property (
        st_r.scanTick |=> (!st_r.scanTick)[*4])
        else $error("scan ticks closer than expected");
    chk_scan_count: assert property (
        st_r.scanTick |-> st_r.scanCnt == dic_pkg::CNT_RST)
        else $error("scan tick not at period start");

endmodule : dic_top

// ===== dv/dic_field_contact.sv
// Field contact wiring model driving the energized input terminals
`timescale 1ns/1ps
module dic_field_contact (
    input  wire logic                       core_clk,     // Bench clock
    input  wire logic [dic_pkg::NUM_CH-1:0] energize,     // Commanded state
    output logic [dic_pkg::NUM_CH-1:0]      inputChannel  // Terminal level
);
    // Contacts move off the sampling edge, like a real wiring change
    initial inputChannel = '0;
    always @(negedge core_clk) begin
        inputChannel <= energize;
    end
endmodule : dic_field_contact

// ===== dv/dic_top_bench.sv
// Self-checking bench for the digital input conditioner
`timescale 1ns/1ps
module dic_top_bench;
    localparam int MS = 4;     // Cycles per ms step, shortened
    localparam int SC = 20;    // Cycles per scan, shortened to 5 ms
    logic                              core_clk = 1'b0;
    logic                              sys_rst  = 1'b1;
    logic [dic_pkg::NUM_CH-1:0]        energize = '0;
    logic [dic_pkg::NUM_CH-1:0]        inputChannel;
    dic_pkg::dic_cfg_t [dic_pkg::NUM_CH-1:0] chanCfg;
    logic [dic_pkg::NUM_CH-1:0]        inputState, consumerState;
    logic [dic_pkg::NUM_CH-1:0]        outputChannel;
    logic                              scanStrobe;
    int                                mismatches = 0, comparisons = 0, n;

    dic_field_contact field (.core_clk(core_clk), .energize(energize),
                             .inputChannel(inputChannel));
    dic_top #(.SCAN_CYCLES(SC), .MS_CYCLES(MS)) uut (
        .core_clk(core_clk), .sys_rst(sys_rst), .inputChannel(inputChannel),
        .chanCfg(chanCfg), .inputState(inputState),
        .consumerState(consumerState), .outputChannel(outputChannel),
        .scanStrobe(scanStrobe));

    // ------------------------------------------------------------
    // Clock, verdict and watchdog
    // ------------------------------------------------------------
    initial forever #50 core_clk = ~core_clk;
    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim
    // Tests take about 500 cycles; a hang ends the run as a failure
    initial begin
        repeat (1500) @(posedge core_clk);
        mismatches++;
        end_sim();
    end

    // ------------------------------------------------------------
    // Compare and measure tasks
    // ------------------------------------------------------------
    task automatic check_bit(input string nm, input logic e, input logic s);
        comparisons++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s expected %b seen %b", nm, e, s);
        end
    endtask : check_bit
    task automatic check_range(input string nm, input int lo, input int hi,
                               input int s);
        comparisons++;
        if (s < lo || s > hi) begin
            mismatches++;
            $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, s);
        end
    endtask : check_range
    // Cycles until the reported state of a channel reaches a level
    task automatic measure(input int ch, input logic v, output int cnt);
        cnt = 0;
        while (inputState[ch] !== v && cnt < 2000) begin
            @(negedge core_clk);
            cnt++;
        end
    endtask : measure
    task automatic drive(input int ch, input logic v);
        @(negedge core_clk);
        energize[ch] <= v;
    endtask : drive

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        chanCfg = '0;
        chanCfg[1].polarityNc = 1'b1;
        repeat (10) @(negedge core_clk);
        check_bit("inputState in reset", 1'b0, inputState[0]);
        sys_rst = 1'b0;
        // Normally-closed channel reports 1 while de-energized
        measure(1, 1'b1, n);
        check_range("nc rise", 1, 30, n);
        // Scan period and consumer/output stage latency
        while (scanStrobe !== 1'b1) @(negedge core_clk);
        check_bit("consumer before", 1'b0, consumerState[1]);
        @(negedge core_clk);
        check_bit("consumer after", 1'b1, consumerState[1]);
        check_bit("output stage lags", 1'b0, outputChannel[1]);
        n = 1;
        while (scanStrobe !== 1'b1) begin
            @(negedge core_clk);
            n++;
        end
        check_range("scan period", SC, SC, n);
        @(negedge core_clk);
        check_bit("output stage", 1'b1, outputChannel[1]);
        // Activation delay 3 ms
        chanCfg[0].actDelay = 21'h000003;
        drive(0, 1'b1);
        measure(0, 1'b1, n);
        check_range("activation", 3 * MS, 2 + SC + 4 * MS + 3, n);
        // Drop-off delay 5 ms
        chanCfg[0].dropDelay = 21'h000005;
        drive(0, 1'b0);
        measure(0, 1'b0, n);
        check_range("drop-off", 5 * MS, 2 + SC + 6 * MS + 3, n);
        // Alternating supply release adds 30 ms
        chanCfg[0] = '0;
        chanCfg[0].acMode = 1'b1;
        drive(0, 1'b1);
        measure(0, 1'b1, n);
        check_range("ac rise", 0, SC + 6, n);
        drive(0, 1'b0);
        measure(0, 1'b0, n);
        check_range("ac release", 30 * MS, 2 + SC + 31 * MS + 3, n);
        // Pulse shorter than the activation delay is cancelled
        chanCfg[0] = '0;
        chanCfg[0].actDelay = 21'h00000a;
        drive(0, 1'b1);
        repeat (SC + 5) @(negedge core_clk);
        energize[0] <= 1'b0;
        repeat (80) @(negedge core_clk);
        check_bit("cancelled pulse", 1'b0, inputState[0]);
        drive(0, 1'b1);
        measure(0, 1'b1, n);
        check_range("restarted delay", 10 * MS, 2 + SC + 11 * MS + 3, n);
        check_bit("other channel", 1'b1, inputState[1]);
        // Normally-closed channel reports 0 once energized
        drive(1, 1'b1);
        measure(1, 1'b0, n);
        check_range("nc energized", 1, SC + 6, n);
        end_sim();
    end
endmodule : dic_top_bench
